// file: src/dcm_pkg.sv
// Purpose: Shared constants for the coded ring oscillator and clock monitor.
// Assumes: 8-bit register port, two address bits.
// Notes:   Control bit layout follows the clock generator control register.
package dcm_pkg;
  // Register offsets
  localparam logic [1:0] ADDR_CTRL  = 2'h0;
  localparam logic [1:0] ADDR_MULT  = 2'h1;
  localparam logic [1:0] ADDR_STAGE = 2'h2;
  localparam logic [1:0] ADDR_DIV   = 2'h3;
  // Control register bit positions
  localparam int BIT_IRQ_EN  = 7;
  localparam int BIT_FAIL    = 6;
  localparam int BIT_MON_EN  = 5;
  localparam int BIT_CS      = 4;
  localparam int BIT_INT_ON  = 3;
  localparam int BIT_INT_STB = 2;
  localparam int BIT_EXT_ON  = 1;
  localparam int BIT_EXT_STB = 0;
  // Values after reset
  localparam logic [7:0] CTRL_RST  = 8'h08;
  localparam logic [6:0] MULT_RST  = 7'h01;
  localparam logic [7:0] STAGE_RST = 8'h00;
  localparam logic [3:0] DIV_RST   = 4'h0;
  // Stage code steps and ring geometry
  localparam logic [7:0] STEP_COARSE  = 8'h20;
  localparam logic [7:0] STEP_FINE    = 8'h01;
  localparam logic [3:0] DIV_MAX_EFF  = 4'h9;
  localparam logic [3:0] DIV_TOP      = 4'hF;
  localparam logic [5:0] RING_MIN     = 6'h11;
  localparam logic [5:0] RING_EXTRA   = 6'h02;
  localparam logic [5:0] RING_TOP     = 6'h1F;
  localparam logic [5:0] RING_HALVED  = 6'h22;
  localparam logic [2:0] UPPER_TOP    = 3'h7;
  // Base clock, in hertz
  localparam logic [31:0] BASE_FREQ_HZ = 32'h0004_B000;
endpackage : dcm_pkg

// file: src/dcm_sync2.sv
// Purpose: Two-flop synchroniser for asynchronous levels.
// Assumes: Inputs are slow levels or clocks well below the system rate.
// Notes:   First stage is read by the second stage only.
`timescale 1ns/1ps
module dcm_sync2 #(
  parameter int W = 1
) (
  input  wire logic         i_sys_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  if (W < 1) begin : g_bad_width
    $error("dcm_sync2: W must be at least 1");
  end
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;
  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign o_sync = sync_ff;
endmodule : dcm_sync2

// file: src/dcm_ring.sv
// Purpose: Model of the ring, its fine-adjust frame and the post-divider.
// Assumes: One stage delay is one system clock cycle.
// Notes:   Output toggles once per generated period.
`timescale 1ns/1ps
module dcm_ring (
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_stage,
  input  wire logic [3:0] i_div,
  output logic            o_tick,
  output logic            o_clk
);
  logic [5:0] stg_cnt_ff;
  logic [8:0] div_cnt_ff;
  logic [4:0] frame_ff;
  logic       tick_ff;
  logic       clk_ff;
  logic [5:0] nxt_stg_cnt;
  logic [8:0] nxt_div_cnt;
  logic [4:0] nxt_frame;
  logic       nxt_tick;
  logic       nxt_clk;
  logic [4:0] frame_rev;
  logic       long_cyc;
  logic [5:0] ring_len;
  logic [3:0] div_eff;
  logic [9:0] div_lim;
  always_comb begin
    // Bit-reversed frame spreads long cycles evenly over 32
    frame_rev = {frame_ff[0], frame_ff[1], frame_ff[2], frame_ff[3], frame_ff[4]};
    long_cyc  = (frame_rev < i_stage[4:0]);
    if (i_stage[7:5] == dcm_pkg::UPPER_TOP) begin
      ring_len = long_cyc ? dcm_pkg::RING_HALVED : dcm_pkg::RING_TOP;
    end else begin
      ring_len = dcm_pkg::RING_MIN + {2'b00, i_stage[7:5], 1'b0}
               + (long_cyc ? dcm_pkg::RING_EXTRA : 6'h00);
    end
    div_eff = (i_div > dcm_pkg::DIV_MAX_EFF) ? dcm_pkg::DIV_MAX_EFF : i_div;
    div_lim = (10'h001 << div_eff) - 10'h001;
    nxt_stg_cnt = stg_cnt_ff + 6'h01;
    nxt_div_cnt = div_cnt_ff;
    nxt_frame   = frame_ff;
    nxt_tick    = 1'b0;
    nxt_clk     = clk_ff;
    if (stg_cnt_ff >= ring_len - 6'h01) begin
      nxt_stg_cnt = 6'h00;
      nxt_frame   = frame_ff + 5'h01;
      if ({1'b0, div_cnt_ff} >= div_lim) begin
        nxt_div_cnt = 9'h000;
        nxt_tick    = 1'b1;
        nxt_clk     = ~clk_ff;
      end else begin
        nxt_div_cnt = div_cnt_ff + 9'h001;
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stg_cnt_ff <= 6'h00;
      div_cnt_ff <= 9'h000;
      frame_ff   <= 5'h00;
      tick_ff    <= 1'b0;
      clk_ff     <= 1'b0;
    end else begin
      stg_cnt_ff <= nxt_stg_cnt;
      div_cnt_ff <= nxt_div_cnt;
      frame_ff   <= nxt_frame;
      tick_ff    <= nxt_tick;
      clk_ff     <= nxt_clk;
    end
  end
  assign o_tick = tick_ff;
  assign o_clk  = clk_ff;
endmodule : dcm_ring

// file: src/dcm_top.sv
// Purpose: Coded ring oscillator datapath and clock monitor control.
// Assumes: Stable and inactivity flags arrive asynchronously from analog.
// Notes:   Register port answers reads one cycle later.
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module dcm_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic [1:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_lf_up,
  input  wire logic        i_lf_down,
  input  wire logic        i_lf_coarse,
  input  wire logic        i_int_stable,
  input  wire logic        i_ext_stable,
  input  wire logic        i_int_off,
  input  wire logic        i_ext_off,
  input  wire logic        i_ext_clk,
  output logic [7:0]       o_rdata,
  output logic             o_monitor_req,
  output logic             o_gen_clk,
  output logic             o_gen_tick,
  output logic             o_osc_clk,
  output logic             o_osc_sel_ext,
  output logic             o_tb_clk,
  output logic             o_tb_sel_ext,
  output logic [7:0]       o_stage_code,
  output logic [3:0]       o_divider_code,
  output logic [31:0]      o_target_freq
);
  typedef enum logic [1:0] {
    DCM_CLR_IDLE  = 2'b01,
    DCM_CLR_ARMED = 2'b10
  } dcm_clr_t;

  logic [3:0] sync_out;
  logic       int_stb_s;
  logic       ext_stb_s;
  logic       int_off_s;
  logic       ext_off_s;
  logic       ext_clk_s;
  logic       gen_clk;
  logic       gen_tick;
  dcm_sync2 #(.W(4)) u_sync_flags (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   ({i_int_stable, i_ext_stable, i_int_off, i_ext_off}),
    .o_sync    (sync_out)
  );
  assign {int_stb_s, ext_stb_s, int_off_s, ext_off_s} = sync_out;
  dcm_sync2 #(.W(1)) u_sync_external_clock (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_ext_clk),
    .o_sync    (ext_clk_s)
  );

  // Register file and monitor state
  dcm_clr_t    clr_ff;
  logic        irq_en_ff;
  logic        fail_ff;
  logic        mon_en_ff;
  logic        cs_ff;
  logic        int_on_ff;
  logic        ext_on_ff;
  logic        relock_ff;
  logic        int_stb_d_ff;
  logic [6:0]  mult_ff;
  logic [7:0]  stage_ff;
  logic [3:0]  div_ff;
  logic [7:0]  rdata_ff;
  dcm_clr_t    nxt_clr;
  logic        nxt_irq_en;
  logic        nxt_fail;
  logic        nxt_mon_en;
  logic        nxt_cs;
  logic        nxt_int_on;
  logic        nxt_ext_on;
  logic        nxt_relock;
  logic [6:0]  nxt_mult;
  logic [7:0]  nxt_rdata;
  logic [7:0]  ctrl_view;
  logic        wr_ctrl;
  logic        wr_mult;
  logic        mon_ok;
  logic        fail_int;
  logic        fail_ext;

  assign wr_ctrl = i_wr && (i_addr == dcm_pkg::ADDR_CTRL);
  assign wr_mult = i_wr && (i_addr == dcm_pkg::ADDR_MULT);
  assign mon_ok  = int_on_ff && ext_on_ff && int_stb_s && ext_stb_s && !relock_ff;
  assign fail_int = mon_en_ff && int_off_s;
  assign fail_ext = mon_en_ff && ext_off_s && !int_off_s;

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[dcm_pkg::BIT_IRQ_EN]  = irq_en_ff;
    ctrl_view[dcm_pkg::BIT_FAIL]    = fail_ff;
    ctrl_view[dcm_pkg::BIT_MON_EN]  = mon_en_ff;
    ctrl_view[dcm_pkg::BIT_CS]      = cs_ff;
    ctrl_view[dcm_pkg::BIT_INT_ON]  = int_on_ff;
    ctrl_view[dcm_pkg::BIT_INT_STB] = int_stb_s;
    ctrl_view[dcm_pkg::BIT_EXT_ON]  = ext_on_ff;
    ctrl_view[dcm_pkg::BIT_EXT_STB] = ext_stb_s;
  end

  always_comb begin
    nxt_clr    = clr_ff;
    nxt_irq_en = irq_en_ff;
    nxt_fail   = fail_ff;
    nxt_mon_en = mon_en_ff;
    nxt_cs     = cs_ff;
    nxt_int_on = int_on_ff;
    nxt_ext_on = ext_on_ff;
    nxt_relock = relock_ff;
    nxt_mult   = mult_ff;
    nxt_rdata  = 8'h00;
    if (i_rd) begin
      case (i_addr)
        dcm_pkg::ADDR_CTRL:  nxt_rdata = ctrl_view;
        dcm_pkg::ADDR_MULT:  nxt_rdata = {1'b0, mult_ff};
        dcm_pkg::ADDR_STAGE: nxt_rdata = stage_ff;
        dcm_pkg::ADDR_DIV:   nxt_rdata = {4'h0, div_ff};
        default:             nxt_rdata = 8'h00;
      endcase
    end
    // Read of a set flag arms the clear
    case (clr_ff)
      DCM_CLR_IDLE: begin
        if (i_rd && (i_addr == dcm_pkg::ADDR_CTRL) && fail_ff) begin
          nxt_clr = DCM_CLR_ARMED;
        end
      end
      DCM_CLR_ARMED: begin
        if (wr_ctrl && !i_wdata[dcm_pkg::BIT_FAIL]) begin
          nxt_fail = 1'b0;
          nxt_clr  = DCM_CLR_IDLE;
        end
      end
      default: nxt_clr = DCM_CLR_IDLE;
    endcase
    if (wr_ctrl) begin
      nxt_int_on = i_wdata[dcm_pkg::BIT_INT_ON];
      nxt_ext_on = i_wdata[dcm_pkg::BIT_EXT_ON];
      // Interrupt enable only sticks while the monitor runs or mon_ok holds
      nxt_irq_en = i_wdata[dcm_pkg::BIT_IRQ_EN] && (mon_en_ff || mon_ok);
      if (!i_wdata[dcm_pkg::BIT_MON_EN]) begin
        nxt_mon_en = 1'b0;
      end else if (mon_ok) begin
        nxt_mon_en = 1'b1;
      end
      if (i_wdata[dcm_pkg::BIT_CS] && ext_on_ff && ext_stb_s) begin
        nxt_cs = 1'b1;
      end else if (!i_wdata[dcm_pkg::BIT_CS] && int_on_ff && int_stb_s) begin
        nxt_cs = 1'b0;
      end
    end
    if (wr_mult) begin
      nxt_mult   = i_wdata[6:0];
      nxt_relock = 1'b1;
    end else if (int_stb_s && !int_stb_d_ff) begin
      nxt_relock = 1'b0;
    end
    // Failover overrides the select; a new event beats a clear
    if (fail_int) begin
      nxt_fail = 1'b1;
      nxt_cs   = 1'b1;
      nxt_clr  = clr_ff;
    end else if (fail_ext) begin
      nxt_fail = 1'b1;
      nxt_cs   = 1'b0;
      nxt_clr  = clr_ff;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      clr_ff       <= DCM_CLR_IDLE;
      irq_en_ff    <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_IRQ_EN];
      fail_ff      <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_FAIL];
      mon_en_ff    <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_MON_EN];
      cs_ff        <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_CS];
      int_on_ff    <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_INT_ON];
      ext_on_ff    <= dcm_pkg::CTRL_RST[dcm_pkg::BIT_EXT_ON];
      relock_ff    <= 1'b0;
      int_stb_d_ff <= 1'b0;
      mult_ff      <= dcm_pkg::MULT_RST;
      rdata_ff     <= 8'h00;
    end else begin
      clr_ff       <= nxt_clr;
      irq_en_ff    <= nxt_irq_en;
      fail_ff      <= nxt_fail;
      mon_en_ff    <= nxt_mon_en;
      cs_ff        <= nxt_cs;
      int_on_ff    <= nxt_int_on;
      ext_on_ff    <= nxt_ext_on;
      relock_ff    <= nxt_relock;
      int_stb_d_ff <= int_stb_s;
      mult_ff      <= nxt_mult;
      rdata_ff     <= nxt_rdata;
    end
  end

  // Stage and divider codes
  logic [7:0] nxt_stage;
  logic [3:0] nxt_div;
  logic [7:0] step;
  logic [8:0] sum_up;
  logic [8:0] sum_dn;
  always_comb begin
    step      = i_lf_coarse ? dcm_pkg::STEP_COARSE : dcm_pkg::STEP_FINE;
    sum_up    = {1'b0, stage_ff} + {1'b0, step};
    sum_dn    = {1'b0, stage_ff} - {1'b0, step};
    nxt_stage = stage_ff;
    nxt_div   = div_ff;
    if (i_lf_up && !i_lf_down) begin
      if (!sum_up[8]) begin
        nxt_stage = sum_up[7:0];
      end else if (div_ff != dcm_pkg::DIV_TOP) begin
        nxt_stage = sum_up[7:0];
        nxt_div   = div_ff + 4'h1;
      end else begin
        nxt_stage = 8'hFF;
      end
    end else if (i_lf_down && !i_lf_up) begin
      if (!sum_dn[8]) begin
        nxt_stage = sum_dn[7:0];
      end else if (div_ff != 4'h0) begin
        nxt_stage = sum_dn[7:0];
        nxt_div   = div_ff - 4'h1;
      end else begin
        nxt_stage = 8'h00;
      end
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      stage_ff <= dcm_pkg::STAGE_RST;
      div_ff   <= dcm_pkg::DIV_RST;
    end else begin
      stage_ff <= nxt_stage;
      div_ff   <= nxt_div;
    end
  end

  dcm_ring u_ring (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_stage   (stage_ff),
    .i_div     (div_ff),
    .o_tick    (gen_tick),
    .o_clk     (gen_clk)
  );

  // Output clock switches; a failed side is forced away
  logic        osc_clk_ff;
  logic        tb_clk_ff;
  logic        tb_ext_ff;
  logic        req_ff;
  logic [31:0] freq_ff;
  logic        nxt_tb_ext;
  always_comb begin
    nxt_tb_ext = ext_on_ff;
    if (fail_ff || fail_int || fail_ext) begin
      nxt_tb_ext = nxt_cs;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      osc_clk_ff <= 1'b0;
      tb_clk_ff  <= 1'b0;
      tb_ext_ff  <= 1'b0;
      req_ff     <= 1'b0;
      freq_ff    <= 32'h0000_0000;
    end else begin
      osc_clk_ff <= cs_ff ? ext_clk_s : gen_clk;
      tb_clk_ff  <= tb_ext_ff ? ext_clk_s : gen_clk;
      tb_ext_ff  <= nxt_tb_ext;
      req_ff     <= fail_ff && irq_en_ff;
      freq_ff    <= {25'h000_0000, mult_ff} * dcm_pkg::BASE_FREQ_HZ;
    end
  end

  assign o_rdata        = rdata_ff;
  assign o_monitor_req  = req_ff;
  assign o_gen_clk      = gen_clk;
  assign o_gen_tick     = gen_tick;
  assign o_osc_clk      = osc_clk_ff;
  assign o_osc_sel_ext  = cs_ff;
  assign o_tb_clk       = tb_clk_ff;
  assign o_tb_sel_ext   = tb_ext_ff;
  assign o_stage_code   = stage_ff;
  assign o_divider_code = div_ff;
  assign o_target_freq  = freq_ff;

  default clocking dcm_cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  clr_needs_read_a: assert property (
    $fell(fail_ff) |-> $past(clr_ff == DCM_CLR_ARMED && wr_ctrl && !i_wdata[6]))
    else $error("fail flag cleared without read and zero write");
  clr_one_keeps_a: assert property (
    fail_ff && wr_ctrl && i_wdata[dcm_pkg::BIT_FAIL] |=> fail_ff)
    else $error("writing one changed the fail flag");
  mon_en_gate_a: assert property (
    $rose(mon_en_ff) |-> $past(int_on_ff && ext_on_ff && int_stb_s && ext_stb_s))
    else $error("monitor enabled without both clocks stable");
  mon_en_hold_a: assert property (
    mon_en_ff && !(wr_ctrl && !i_wdata[dcm_pkg::BIT_MON_EN]) |=> mon_en_ff)
    else $error("monitor enable dropped without software");
  failover_sel_a: assert property (
    mon_en_ff && int_off_s |=> fail_ff && cs_ff ##1 o_osc_sel_ext && tb_ext_ff)
    else $error("inactive internal clock not deselected");
  div_carry_a: assert property (
    $changed(div_ff) |-> $past(i_lf_up ^ i_lf_down))
    else $error("divider code moved without stage carry or borrow");
  div_step_a: assert property (
    i_lf_up && !i_lf_down && sum_up[8] && div_ff != 4'hF |=> div_ff == $past(div_ff) + 4'h1)
    else $error("stage carry did not step the divider code");
  coarse_step_a: assert property (
    i_lf_up && !i_lf_down && i_lf_coarse && !sum_up[8] |=> stage_ff == $past(stage_ff) + 8'h20)
    else $error("coarse step is not bit five");
  relock_wait_a: assert property (
    relock_ff |=> !$rose(mon_en_ff))
    else $error("monitor re-enabled before internal clock stable");
  cs_gate_a: assert property (
    $rose(cs_ff) |-> $past(ext_on_ff && ext_stb_s) || $past(fail_int))
    else $error("external clock selected while not ready");

  failover_c: cover property (mon_en_ff && ext_off_s ##1 fail_ff);
  clear_c:    cover property (clr_ff == DCM_CLR_ARMED ##1 $fell(fail_ff));
  carry_c:    cover property ($rose(div_ff[0]) && i_lf_coarse);
  relock_c:   cover property (wr_mult ##[1:20] $fell(relock_ff));
endmodule : dcm_top

// file: tb/dcm_tb.sv
// Purpose: Self-checking bench for the ring oscillator datapath and clock monitor.
// Assumes: Reads answer one cycle after the strobe; loop filter steps driven directly.
// Notes:   Periods are measured between generated ticks, after three settling ticks.
`timescale 1ns/1ps
module tb;
  logic        i_sys_clk;
  logic        i_rst_n;
  logic [1:0]  i_addr;
  logic [7:0]  i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic        i_lf_up;
  logic        i_lf_down;
  logic        i_lf_coarse;
  logic        i_int_stable;
  logic        i_ext_stable;
  logic        i_int_off;
  logic        i_ext_off;
  logic        i_ext_clk;
  logic [7:0]  o_rdata;
  logic        o_monitor_req;
  logic        o_gen_clk;
  logic        o_gen_tick;
  logic        o_osc_clk;
  logic        o_osc_sel_ext;
  logic        o_tb_clk;
  logic        o_tb_sel_ext;
  logic [7:0]  o_stage_code;
  logic [3:0]  o_divider_code;
  logic [31:0] o_target_freq;
  logic [1:0]  ext_cnt;
  logic [2:0]  ext_hist;
  int          n_mismatch;
  int          n_tests;
  int          cyc;

  dcm_top i_dcm_top (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_addr        (i_addr),
    .i_wdata       (i_wdata),
    .i_wr          (i_wr),
    .i_rd          (i_rd),
    .i_lf_up       (i_lf_up),
    .i_lf_down     (i_lf_down),
    .i_lf_coarse   (i_lf_coarse),
    .i_int_stable  (i_int_stable),
    .i_ext_stable  (i_ext_stable),
    .i_int_off     (i_int_off),
    .i_ext_off     (i_ext_off),
    .i_ext_clk     (i_ext_clk),
    .o_rdata       (o_rdata),
    .o_monitor_req (o_monitor_req),
    .o_gen_clk     (o_gen_clk),
    .o_gen_tick    (o_gen_tick),
    .o_osc_clk     (o_osc_clk),
    .o_osc_sel_ext (o_osc_sel_ext),
    .o_tb_clk      (o_tb_clk),
    .o_tb_sel_ext  (o_tb_sel_ext),
    .o_stage_code  (o_stage_code),
    .o_divider_code(o_divider_code),
    .o_target_freq (o_target_freq)
  );

  always #12.5 i_sys_clk = ~i_sys_clk;

  // Slow external clock, kept on the system edge so sampling stays deterministic
  always @(posedge i_sys_clk) begin
    ext_cnt <= ext_cnt + 2'h1;
    ext_hist <= {ext_hist[1:0], i_ext_clk};
    if (ext_cnt == 2'h2) begin
      i_ext_clk <= ~i_ext_clk;
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1;
    chk({24'h00_0000, o_rdata}, {24'h00_0000, exp}, "register read");
  endtask : rd

  task automatic lf(input logic up, input logic coarse);
    @(posedge i_sys_clk);
    i_lf_up     <= up;
    i_lf_down   <= ~up;
    i_lf_coarse <= coarse;
    @(posedge i_sys_clk);
    i_lf_up     <= 1'b0;
    i_lf_down   <= 1'b0;
  endtask : lf

  task automatic waitc(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : waitc

  // Sum of n generated periods; bounded so a dead ring ends the run
  task automatic meas(input int n, output int c);
    int k;
    int t;
    logic g;
    g = 1'b0;
    k = 0;
    c = 0;
    t = 0;
    while (k <= n) begin
      @(posedge i_sys_clk);
      #1;
      t++;
      if (k > 0) c++;
      if (o_gen_tick === 1'b1) begin
        if (k > 0) chk(o_gen_clk, {31'h0000_0000, ~g}, "generated clock toggle");
        g = o_gen_clk;
        k++;
      end
      if (t > 40000) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: generated tick timeout", $time);
        final_report();
      end
    end
  endtask : meas

  task automatic period(input int n, input logic [31:0] exp);
    meas(2, cyc);
    meas(n, cyc);
    chk(cyc, exp, "generated period");
  endtask : period

  // Switches follow their source: external through two sync flops plus the mux flop, generated through the mux flop only
  task automatic clk_track(input logic ext_osc, input logic ext_tb);
    logic gen_d;
    gen_d = o_gen_clk;
    repeat (8) begin
      @(posedge i_sys_clk);
      #1;
      chk(o_osc_clk, ext_osc ? ext_hist[2] : gen_d, "osc clock source");
      chk(o_tb_clk, ext_tb ? ext_hist[2] : gen_d, "timebase clock source");
      gen_d = o_gen_clk;
    end
  endtask : clk_track

  task automatic wait_req;
    int t;
    t = 0;
    while (o_monitor_req !== 1'b1) begin
      @(posedge i_sys_clk);
      #1;
      t++;
      if (t > 20) begin
        n_mismatch++;
        $display("CHECK FAILED at %0t: monitor request timeout", $time);
        final_report();
      end
    end
  endtask : wait_req

  initial begin
    i_sys_clk    = 1'b0;
    i_rst_n      = 1'b0;
    i_addr       = 2'h0;
    i_wdata      = 8'h00;
    i_wr         = 1'b0;
    i_rd         = 1'b0;
    i_lf_up      = 1'b0;
    i_lf_down    = 1'b0;
    i_lf_coarse  = 1'b0;
    i_int_stable = 1'b0;
    i_ext_stable = 1'b0;
    i_int_off    = 1'b0;
    i_ext_off    = 1'b0;
    i_ext_clk    = 1'b0;
    ext_cnt      = 2'h0;
    ext_hist     = 3'h0;
    n_mismatch   = 0;
    n_tests      = 0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    waitc(2);
    chk(o_target_freq, dcm_pkg::BASE_FREQ_HZ, "base frequency");
    rd(dcm_pkg::ADDR_CTRL, dcm_pkg::CTRL_RST);
    rd(dcm_pkg::ADDR_MULT, {1'b0, dcm_pkg::MULT_RST});
    rd(dcm_pkg::ADDR_STAGE, dcm_pkg::STAGE_RST);
    rd(dcm_pkg::ADDR_DIV, {4'h0, dcm_pkg::DIV_RST});
    // Ring geometry and fine-adjust frame
    period(1, 32'h0000_0011);
    lf(1'b1, 1'b0);
    waitc(1);
    chk(o_stage_code, 32'h0000_0001, "fine step");
    period(32, 32'h0000_0222);
    for (int i = 0; i < 7; i++) lf(1'b1, 1'b1);
    waitc(1);
    chk(o_stage_code, 32'h0000_00E1, "coarse steps");
    period(32, 32'h0000_03E3);
    lf(1'b0, 1'b0);
    period(1, 32'h0000_001F);
    // Carry into the divider, then borrow back
    lf(1'b1, 1'b1);
    waitc(1);
    chk({o_divider_code, o_stage_code}, 32'h0000_0100, "carry");
    period(1, 32'h0000_0022);
    lf(1'b0, 1'b1);
    waitc(1);
    chk({o_divider_code, o_stage_code}, 32'h0000_00E0, "borrow");
    // Divider codes above nine act as nine
    for (int i = 0; i < 73; i++) lf(1'b1, 1'b1);
    rd(dcm_pkg::ADDR_DIV, 8'h0A);
    wr(dcm_pkg::ADDR_STAGE, 8'hFF);
    rd(dcm_pkg::ADDR_STAGE, 8'h00);
    period(1, 32'h0000_2200);
    // Monitor enable gating and clock select
    @(posedge i_sys_clk);
    i_int_stable <= 1'b1;
    i_ext_stable <= 1'b1;
    waitc(4);
    wr(dcm_pkg::ADDR_CTRL, 8'h28);
    rd(dcm_pkg::ADDR_CTRL, 8'h0D);
    wr(dcm_pkg::ADDR_CTRL, 8'h0A);
    wr(dcm_pkg::ADDR_CTRL, 8'h1A);
    waitc(2);
    chk(o_osc_sel_ext, 32'h0000_0001, "select external");
    clk_track(1'b1, 1'b1);
    wr(dcm_pkg::ADDR_CTRL, 8'hBA);
    rd(dcm_pkg::ADDR_CTRL, 8'hBF);
    @(posedge i_sys_clk);
    i_ext_stable <= 1'b0;
    waitc(4);
    rd(dcm_pkg::ADDR_CTRL, 8'hBE);
    // External clock lost: failover to the internal clock
    @(posedge i_sys_clk);
    i_ext_off <= 1'b1;
    wait_req();
    waitc(3);
    chk(o_osc_sel_ext, 32'h0000_0000, "failover osc");
    chk(o_tb_sel_ext, 32'h0000_0000, "failover timebase");
    clk_track(1'b0, 1'b0);
    // Zero write without a prior read, and a one write, leave the flag
    wr(dcm_pkg::ADDR_CTRL, 8'hAA);
    waitc(2);
    chk(o_monitor_req, 32'h0000_0001, "clear needs read");
    wr(dcm_pkg::ADDR_CTRL, 8'hEA);
    waitc(2);
    chk(o_monitor_req, 32'h0000_0001, "one write ignored");
    @(posedge i_sys_clk);
    i_ext_off <= 1'b0;
    waitc(4);
    rd(dcm_pkg::ADDR_CTRL, 8'hEE);
    wr(dcm_pkg::ADDR_CTRL, 8'h0A);
    waitc(2);
    chk(o_monitor_req, 32'h0000_0000, "flag cleared");
    rd(dcm_pkg::ADDR_CTRL, 8'h0E);
    // Multiply change blocks monitor enable until relock
    @(posedge i_sys_clk);
    i_ext_stable <= 1'b1;
    wr(dcm_pkg::ADDR_MULT, 8'h04);
    rd(dcm_pkg::ADDR_MULT, 8'h04);
    chk(o_target_freq, dcm_pkg::BASE_FREQ_HZ * 32'h0000_0004, "scaled freq");
    wr(dcm_pkg::ADDR_CTRL, 8'h2A);
    rd(dcm_pkg::ADDR_CTRL, 8'h0F);
    @(posedge i_sys_clk);
    i_int_stable <= 1'b0;
    waitc(4);
    @(posedge i_sys_clk);
    i_int_stable <= 1'b1;
    waitc(4);
    wr(dcm_pkg::ADDR_CTRL, 8'h2A);
    rd(dcm_pkg::ADDR_CTRL, 8'h2F);
    // Internal clock lost: failover to the external clock
    @(posedge i_sys_clk);
    i_int_off <= 1'b1;
    waitc(4);
    chk(o_osc_sel_ext, 32'h0000_0001, "failover to external");
    chk(o_tb_sel_ext, 32'h0000_0001, "timebase to external");
    clk_track(1'b1, 1'b1);
    rd(dcm_pkg::ADDR_CTRL, 8'h7F);
    final_report();
  end
endmodule : tb
